// >>> rtl/idc_pkg.sv
// package: instruction decoder constants, classes and field layout
package idc_pkg;
    localparam int unsigned INSTR_W      = 14;
    localparam int unsigned OSC_PER_ICYC = 4;
    localparam logic [1:0]  PHASE_RST    = 2'h0;
    localparam logic [1:0]  PHASE_LAST   = 2'(OSC_PER_ICYC - 1);
    localparam logic [13:0] NOP_WORD     = 14'h0000;
    localparam int unsigned F_LSB        = 0;
    localparam int unsigned D_POS        = 7;
    localparam int unsigned B_LSB        = 7;
    localparam int unsigned K11_LSB      = 0;
    localparam int unsigned K8_LSB       = 0;
    localparam int unsigned N_POS        = 2;
    localparam int unsigned M_LSB        = 0;
    localparam logic [6:0]  FILE_MIN     = 7'h00;
    localparam logic [6:0]  FILE_MAX     = 7'h7f;
    localparam logic [6:0]  INDF0_ADDR   = 7'h00;
    localparam logic [6:0]  INDF1_ADDR   = 7'h01;
    localparam logic [1:0]  CYC_ONE      = 2'h1;
    localparam logic [1:0]  CYC_TWO      = 2'h2;

    typedef enum logic [1:0] {
        IDC_CLS_BYTE,
        IDC_CLS_BIT,
        IDC_CLS_LIT
    } idc_class_t;

    typedef enum logic [3:0] {
        IDC_OP_PLAIN,
        IDC_OP_CALL,
        IDC_OP_INVOKE_ACC,
        IDC_OP_RETURN,
        IDC_OP_EXIT_LIT,
        IDC_OP_INT_EXIT,
        IDC_OP_JUMP,
        IDC_OP_REL_JUMP,
        IDC_OP_ACC_JUMP,
        IDC_OP_SKIP_SET,
        IDC_OP_SKIP_CLR,
        IDC_OP_DEC_SKIP,
        IDC_OP_INC_SKIP,
        IDC_OP_PTR_STEP
    } idc_op_t;
endpackage

// >>> rtl/idc_field_extract.sv
// module: combinational operand field extraction and classification
`timescale 1ns/1ps
`default_nettype none
module idc_field_extract (
    input  wire logic [13:0]        instr,
    output idc_pkg::idc_class_t     cls,
    output idc_pkg::idc_op_t        op,
    output logic                    dest_file,
    output logic [6:0]              file_addr,
    output logic [2:0]              bit_idx,
    output logic [10:0]             lit11,
    output logic [7:0]              lit8,
    output logic                    ptr_num,
    output logic [1:0]              step_mode,
    output logic                    uses_file
);
    always_comb begin
        // classes by the top two opcode bits
        case (instr[13:12])
            2'h1:    cls = idc_pkg::IDC_CLS_BIT;
            2'h0:    cls = idc_pkg::IDC_CLS_BYTE;
            // shift and carry/borrow arithmetic sit among the literal opcodes
            2'h3:    cls = (instr[11:8] inside {4'h5, 4'h6, 4'h7, 4'hb, 4'hd}) ? idc_pkg::IDC_CLS_BYTE
                                                                           : idc_pkg::IDC_CLS_LIT;
            default: cls = idc_pkg::IDC_CLS_LIT;
        endcase
        // a store to file (bit 7 set) keeps byte class and its read
        if (instr[13:7] == 7'h00) begin
            cls = idc_pkg::IDC_CLS_LIT;
        end
    end

    always_comb begin
        op = idc_pkg::IDC_OP_PLAIN;
        // control words without operands match on every bit; only operand bits are don't-care
        casez (instr)
            14'b10_0???_????_????: op = idc_pkg::IDC_OP_CALL;
            14'b10_1???_????_????: op = idc_pkg::IDC_OP_JUMP;
            14'b11_001?_????_????: op = idc_pkg::IDC_OP_REL_JUMP;
            14'b00_0000_0000_1010: op = idc_pkg::IDC_OP_INVOKE_ACC;
            14'b00_0000_0000_1000: op = idc_pkg::IDC_OP_RETURN;
            14'b00_0000_0000_1001: op = idc_pkg::IDC_OP_INT_EXIT;
            14'b00_0000_0000_1011: op = idc_pkg::IDC_OP_ACC_JUMP;
            14'b11_0100_????_????: op = idc_pkg::IDC_OP_EXIT_LIT;
            // both step directions, load and store, share one format
            14'b00_0000_0001_????: op = idc_pkg::IDC_OP_PTR_STEP;
            14'b01_10??_????_????: op = idc_pkg::IDC_OP_SKIP_CLR;
            14'b01_11??_????_????: op = idc_pkg::IDC_OP_SKIP_SET;
            14'b00_1011_????_????: op = idc_pkg::IDC_OP_DEC_SKIP;
            14'b00_1111_????_????: op = idc_pkg::IDC_OP_INC_SKIP;
            default:               op = idc_pkg::IDC_OP_PLAIN;
        endcase
    end

    assign dest_file = instr[idc_pkg::D_POS];
    assign file_addr = instr[idc_pkg::F_LSB +: 7];
    assign bit_idx   = instr[idc_pkg::B_LSB +: 3];
    assign lit11     = instr[idc_pkg::K11_LSB +: 11];
    assign lit8      = instr[idc_pkg::K8_LSB +: 8];
    assign ptr_num   = instr[idc_pkg::N_POS];
    assign step_mode = instr[idc_pkg::M_LSB +: 2];
    assign uses_file = (cls != idc_pkg::IDC_CLS_LIT);
endmodule
`default_nettype wire

// >>> rtl/idc_decoder.sv
// module: instruction decoder with instruction-cycle timing
`timescale 1ns/1ps
`default_nettype none
module idc_decoder (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic [13:0]        fetch_word,
    input  wire logic               skip_cond,
    input  wire logic               ptr_prog_mem,
    output logic                    icyc_start,
    output logic [1:0]              phase,
    output idc_pkg::idc_class_t     cls_out,
    output idc_pkg::idc_op_t        op_out,
    output logic                    dest_file_out,
    output logic [6:0]              file_addr_out,
    output logic [2:0]              bit_idx_out,
    output logic [10:0]             lit11_out,
    output logic [7:0]              lit8_out,
    output logic                    ptr_num_out,
    output logic [1:0]              step_mode_out,
    output logic                    file_rd,
    output logic                    file_wr,
    output logic                    acc_wr,
    output logic                    flush,
    output logic                    stall,
    output logic                    exec_valid
);
    logic [1:0]              phase_q;
    logic [13:0]             ir_q;
    logic                    empty_q;
    logic [1:0]              extra_q;
    idc_pkg::idc_class_t     cls;
    idc_pkg::idc_op_t        op;
    logic                    dest_file;
    logic [6:0]              file_addr;
    logic [2:0]              bit_idx;
    logic [10:0]             lit11;
    logic [7:0]              lit8;
    logic                    ptr_num;
    logic [1:0]              step_mode;
    logic                    uses_file;
    logic                    last_ph;
    logic                    is_indirect;
    logic                    keep_q;
    logic                    take_branch;
    logic                    pm_penalty;
    logic [1:0]              cost;

    idc_field_extract u_fx (
        .instr     (ir_q),
        .cls       (cls),
        .op        (op),
        .dest_file (dest_file),
        .file_addr (file_addr),
        .bit_idx   (bit_idx),
        .lit11     (lit11),
        .lit8      (lit8),
        .ptr_num   (ptr_num),
        .step_mode (step_mode),
        .uses_file (uses_file)
    );

    function automatic logic always_two(input idc_pkg::idc_op_t o);
        case (o)
            idc_pkg::IDC_OP_CALL, idc_pkg::IDC_OP_INVOKE_ACC, idc_pkg::IDC_OP_RETURN,
            idc_pkg::IDC_OP_EXIT_LIT, idc_pkg::IDC_OP_INT_EXIT, idc_pkg::IDC_OP_JUMP,
            idc_pkg::IDC_OP_REL_JUMP, idc_pkg::IDC_OP_ACC_JUMP: always_two = 1'b1;
            default: always_two = 1'b0;
        endcase
    endfunction

    function automatic logic is_skip(input idc_pkg::idc_op_t o);
        is_skip = (o == idc_pkg::IDC_OP_SKIP_SET) || (o == idc_pkg::IDC_OP_SKIP_CLR) ||
                  (o == idc_pkg::IDC_OP_DEC_SKIP) || (o == idc_pkg::IDC_OP_INC_SKIP);
    endfunction

    assign last_ph     = (phase_q == idc_pkg::PHASE_LAST);
    assign is_indirect = uses_file &&
                         ((file_addr == idc_pkg::INDF0_ADDR) || (file_addr == idc_pkg::INDF1_ADDR));
    assign take_branch = always_two(op) || (is_skip(op) && skip_cond);
    assign pm_penalty  = is_indirect && ptr_prog_mem;
    assign cost        = {1'b0, take_branch} + {1'b0, pm_penalty};

    // quarter-rate sequencer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= idc_pkg::PHASE_RST;
        end else begin
            phase_q <= phase_q + 2'h1;
        end
    end

    // instruction register: holds while extra cycles run and over a penalty cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ir_q <= idc_pkg::NOP_WORD;
        end else if (last_ph && extra_q == 2'h0 && !(empty_q && keep_q)) begin
            ir_q <= fetch_word;
        end
    end

    // empty cycles owed by the instruction that just finished
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            extra_q <= 2'h0;
            empty_q <= 1'b0;
        end else if (last_ph) begin
            if (extra_q != 2'h0) begin
                extra_q <= extra_q - 2'h1;
                empty_q <= 1'b1;
            end else if (empty_q || cost == 2'h0) begin
                // an empty cycle decodes nothing and owes nothing
                empty_q <= 1'b0;
            end else begin
                // first owed cycle follows at once, the rest are counted
                extra_q <= cost - 2'h1;
                empty_q <= 1'b1;
            end
        end
    end

    // word fetched under a penalty is kept, under a branch thrown away
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            keep_q <= 1'b0;
        end else if (last_ph && extra_q == 2'h0 && !empty_q) begin
            keep_q <= !take_branch;
        end
    end

    // registered decode outputs, reloaded every clock from the decode of the instruction register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            icyc_start    <= 1'b0;
            phase         <= idc_pkg::PHASE_RST;
            cls_out       <= idc_pkg::IDC_CLS_LIT;
            op_out        <= idc_pkg::IDC_OP_PLAIN;
            dest_file_out <= 1'b0;
            file_addr_out <= idc_pkg::FILE_MIN;
            bit_idx_out   <= 3'h0;
            lit11_out     <= 11'h000;
            lit8_out      <= 8'h00;
            ptr_num_out   <= 1'b0;
            step_mode_out <= 2'h0;
            exec_valid    <= 1'b0;
        end else begin
            icyc_start    <= last_ph;
            phase         <= phase_q + 2'h1;
            cls_out       <= cls;
            op_out        <= op;
            dest_file_out <= dest_file;
            file_addr_out <= file_addr;
            bit_idx_out   <= bit_idx;
            lit11_out     <= lit11;
            lit8_out      <= lit8;
            ptr_num_out   <= ptr_num;
            step_mode_out <= step_mode;
            exec_valid    <= !empty_q && (phase_q == idc_pkg::PHASE_RST);
        end
    end

    // file access strobes: read in quarter 1, write in quarter 3
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            file_rd <= 1'b0;
            file_wr <= 1'b0;
            acc_wr  <= 1'b0;
        end else begin
            // read even for write-only operations such as store to file
            file_rd <= !empty_q && uses_file && (phase_q == 2'h0);
            file_wr <= !empty_q && uses_file && (phase_q == 2'h2) &&
                       (dest_file || cls == idc_pkg::IDC_CLS_BIT);
            acc_wr  <= !empty_q && cls == idc_pkg::IDC_CLS_BYTE && !dest_file &&
                       (phase_q == 2'h2);
        end
    end

    // flush: discard prefetched word when a branch or taken skip executes, not for a penalty alone
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flush <= 1'b0;
            stall <= 1'b0;
        end else begin
            flush <= last_ph && !empty_q && extra_q == 2'h0 && take_branch;
            // fetch must not advance while a kept word waits out its penalty
            stall <= (extra_q != 2'h0) || (empty_q && keep_q);
        end
    end

    // instruction cycle lasts four clocks
    property icyc_period_p;
        @(posedge clk) disable iff (!rst_n)
        icyc_start |=> !icyc_start [*3] ##1 icyc_start;
    endproperty
    icyc_period_a: assert property (icyc_period_p) else $error("instruction cycle not four clocks");

    sequence taken_branch_s;
        last_ph && !empty_q && extra_q == 2'h0 && always_two(op);
    endsequence
    branch_two_a: assert property (@(posedge clk) disable iff (!rst_n)
        taken_branch_s |=> (flush && empty_q) ##1 !exec_valid) else $error("branch did not add empty cycle");

    skip_not_taken_a: assert property (@(posedge clk) disable iff (!rst_n)
        last_ph && !empty_q && extra_q == 2'h0 && is_skip(op) && !skip_cond && !(is_indirect && ptr_prog_mem)
        |=> (!flush && !empty_q) ##1 exec_valid) else $error("untaken skip cost a cycle");

    plain_one_a: assert property (@(posedge clk) disable iff (!rst_n)
        last_ph && !empty_q && extra_q == 2'h0 && op == idc_pkg::IDC_OP_PLAIN && !(is_indirect && ptr_prog_mem)
        |=> !empty_q ##1 exec_valid) else $error("plain instruction took extra cycle");

    indirect_extra_a: assert property (@(posedge clk) disable iff (!rst_n)
        last_ph && !empty_q && extra_q == 2'h0 && is_indirect && ptr_prog_mem
        |=> empty_q ##1 !exec_valid) else $error("indirect penalty missing");

    read_before_write_a: assert property (@(posedge clk) disable iff (!rst_n)
        file_wr |-> $past(file_rd, 2)) else $error("file write without prior read");

    acc_dest_a: assert property (@(posedge clk) disable iff (!rst_n)
        acc_wr |-> !file_wr && !dest_file_out) else $error("accumulator and file both written");

    empty_no_access_a: assert property (@(posedge clk) disable iff (!rst_n)
        $past(empty_q) && empty_q |-> !file_rd && !exec_valid) else $error("empty cycle accessed file");
endmodule
`default_nettype wire

// >>> tb/idc_prog_mem_model.sv
// partner model: program memory fetch path with per-word skip and pointer attributes
`timescale 1ns/1ps
`default_nettype none
module idc_prog_mem_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [1:0]  phase,
    input  wire logic        stall,
    output logic [13:0]      fetch_word,
    output logic             skip_cond,
    output logic             ptr_prog_mem
);
    // entry: {skip taken, pointer in program memory, word}
    logic [15:0] q[$];
    logic        shown_q;

    // a word counts as taken only if it was on the lines at the latch edge
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fetch_word   <= idc_pkg::NOP_WORD;
            skip_cond    <= 1'b0;
            ptr_prog_mem <= 1'b0;
            shown_q      <= 1'b0;
        end else begin
            if (phase == 2'h3 && !stall) begin
                // attributes follow the word through its own execution cycle
                skip_cond    <= shown_q ? q[0][15] : 1'b0;
                ptr_prog_mem <= shown_q ? q[0][14] : 1'b0;
                if (shown_q) void'(q.pop_front());
            end
            shown_q    <= q.size() != 0;
            fetch_word <= (q.size() != 0) ? q[0][13:0] : idc_pkg::NOP_WORD;
        end
    end
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// testbench: decoder against a field and cycle-count model, fed by the memory model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic                clk, rst_n, skip_cond, ptr_prog_mem, icyc_start, dest_file_out, ptr_num_out;
    logic                file_rd, file_wr, acc_wr, flush, stall, exec_valid;
    logic [13:0]         fetch_word;
    logic [1:0]          phase, step_mode_out;
    idc_pkg::idc_class_t cls_out;
    idc_pkg::idc_op_t    op_out;
    logic [6:0]          file_addr_out;
    logic [2:0]          bit_idx_out;
    logic [10:0]         lit11_out;
    logic [7:0]          lit8_out;
    int                  n_tests, n_mismatch;
    logic [13:0]         base [20] = '{14'h0700, 14'h0500, 14'h1000, 14'h1400, 14'h1800, 14'h1c00,
        14'h0b00, 14'h0f00, 14'h2000, 14'h2800, 14'h0008, 14'h0009, 14'h000a, 14'h000b, 14'h3400,
        14'h3200, 14'h0010, 14'h3000, 14'h0080, 14'h3500};
    logic [13:0]         mask [20] = '{14'h00ff, 14'h00ff, 14'h03ff, 14'h03ff, 14'h03ff, 14'h03ff,
        14'h00ff, 14'h00ff, 14'h07ff, 14'h07ff, 14'h0000, 14'h0000, 14'h0000, 14'h0000, 14'h00ff,
        14'h01ff, 14'h000f, 14'h00ff, 14'h007f, 14'h00ff};

    idc_decoder DUT (.clk(clk), .rst_n(rst_n), .fetch_word(fetch_word), .skip_cond(skip_cond),
        .ptr_prog_mem(ptr_prog_mem), .icyc_start(icyc_start), .phase(phase), .cls_out(cls_out),
        .op_out(op_out), .dest_file_out(dest_file_out), .file_addr_out(file_addr_out),
        .bit_idx_out(bit_idx_out), .lit11_out(lit11_out), .lit8_out(lit8_out), .ptr_num_out(ptr_num_out),
        .step_mode_out(step_mode_out), .file_rd(file_rd), .file_wr(file_wr), .acc_wr(acc_wr),
        .flush(flush), .stall(stall), .exec_valid(exec_valid));

    idc_prog_mem_model PM (.clk(clk), .rst_n(rst_n), .phase(phase), .stall(stall),
        .fetch_word(fetch_word), .skip_cond(skip_cond), .ptr_prog_mem(ptr_prog_mem));

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic chk_val(input string nm, input logic [39:0] e, input logic [39:0] g);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_cnt(input string nm, input int e, input int g);
        n_tests++;
        if (g != e) begin
            n_mismatch++;
            $display("wrong value %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    task automatic wait_ev();
        int k = 0;
        do begin
            @(negedge clk);
            k++;
        end while (exec_valid !== 1'b1 && k < 40);
        if (k >= 40) chk_cnt("exec wait", 0, 1);
    endtask

    function automatic void model(input logic [13:0] w, input logic sk, input logic pm,
            output idc_pkg::idc_class_t c, output idc_pkg::idc_op_t o, output int cyc, output int fl,
            output int uf);
        int sop;
        c = idc_pkg::IDC_CLS_LIT;
        o = idc_pkg::IDC_OP_PLAIN;
        uf = 0;
        case (w[13:12])
            2'h0: begin
                if (w[13:7] != 7'h00) begin
                    c = idc_pkg::IDC_CLS_BYTE;
                    uf = 1;
                    if (w[11:8] == 4'hb) o = idc_pkg::IDC_OP_DEC_SKIP;
                    if (w[11:8] == 4'hf) o = idc_pkg::IDC_OP_INC_SKIP;
                end else if (w[6:4] == 3'h1) o = idc_pkg::IDC_OP_PTR_STEP;
                else if (w[6:0] == 7'h08) o = idc_pkg::IDC_OP_RETURN;
                else if (w[6:0] == 7'h09) o = idc_pkg::IDC_OP_INT_EXIT;
                else if (w[6:0] == 7'h0a) o = idc_pkg::IDC_OP_INVOKE_ACC;
                else if (w[6:0] == 7'h0b) o = idc_pkg::IDC_OP_ACC_JUMP;
            end
            2'h1: begin
                c = idc_pkg::IDC_CLS_BIT;
                uf = 1;
                if (w[11]) o = w[10] ? idc_pkg::IDC_OP_SKIP_SET : idc_pkg::IDC_OP_SKIP_CLR;
            end
            2'h2: o = w[11] ? idc_pkg::IDC_OP_JUMP : idc_pkg::IDC_OP_CALL;
            default: begin
                // shifts and carry/borrow arithmetic are byte operations here
                if (w[11:8] inside {4'h5, 4'h6, 4'h7, 4'hb, 4'hd}) begin
                    c = idc_pkg::IDC_CLS_BYTE;
                    uf = 1;
                end
                if (w[11:8] == 4'h4) o = idc_pkg::IDC_OP_EXIT_LIT;
                if (w[11:9] == 3'h1) o = idc_pkg::IDC_OP_REL_JUMP;
            end
        endcase
        sop = int'(o inside {idc_pkg::IDC_OP_SKIP_SET, idc_pkg::IDC_OP_SKIP_CLR, idc_pkg::IDC_OP_DEC_SKIP,
            idc_pkg::IDC_OP_INC_SKIP});
        fl = int'((o != idc_pkg::IDC_OP_PLAIN && o != idc_pkg::IDC_OP_PTR_STEP && sop == 0) || (sop != 0 && sk));
        // indirect ports sit at file addresses 0 and 1
        cyc = 1 + fl + int'(uf != 0 && w[6:1] == 6'h00 && pm);
    endfunction

    task automatic run_one(input logic [13:0] w, input logic sk, input logic pm);
        idc_pkg::idc_class_t c;
        idc_pkg::idc_op_t    o;
        int                  cyc, fl, uf;
        int                  k = 0, clks = 0, nrd = 0, nwr = 0, nacc = 0, nfl = 0, nic = 0;
        model(w, sk, pm, c, o, cyc, fl, uf);
        while (PM.q.size() != 0 && k < 60) begin
            @(negedge clk);
            k++;
        end
        // padding words absorb whatever a flush or an empty cycle discards
        PM.q.push_back({sk, pm, w});
        repeat (3) PM.q.push_back(16'h0000);
        wait_ev();
        wait_ev();
        chk_val("class", 40'(c), 40'(cls_out));
        chk_val("op", 40'(o), 40'(op_out));
        chk_val("fields", 40'({w[7], w[6:0], w[9:7], w[10:0], w[7:0], w[2], w[1:0]}), 40'({dest_file_out,
            file_addr_out, bit_idx_out, lit11_out, lit8_out, ptr_num_out, step_mode_out}));
        do begin
            nrd += int'(file_rd);
            nwr += int'(file_wr);
            nacc += int'(acc_wr);
            nfl += int'(flush);
            nic += int'(icyc_start);
            if ($isunknown({file_rd, file_wr, acc_wr, flush, icyc_start})) chk_cnt("known strobes", 0, 1);
            @(negedge clk);
            clks++;
        end while (exec_valid !== 1'b1 && clks < 40);
        chk_cnt("clocks", 4 * cyc, clks);
        chk_cnt("cycle starts", cyc, nic);
        chk_cnt("flush", fl, nfl);
        chk_cnt("file_rd", uf, nrd);
        if (o == idc_pkg::IDC_OP_PLAIN && uf != 0) begin
            chk_cnt("file_wr", int'(c == idc_pkg::IDC_CLS_BIT || w[7]), nwr);
            chk_cnt("acc_wr", int'(c == idc_pkg::IDC_CLS_BYTE && !w[7]), nacc);
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // runs take about 2000 clocks
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        print_verdict();
    end

    initial begin
        logic [13:0] w;
        logic        fm;
        rst_n = 1'b0;
        n_tests = 0;
        n_mismatch = 0;
        void'($urandom(73));
        repeat (3) PM.q.push_back(16'h0000);
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 20; i++) begin
            for (int j = 0; j < 6; j++) begin
                w = base[i] | (14'($urandom) & mask[i]);
                fm = mask[i][6:0] == 7'h7f;
                if (fm && j[0]) w[6:1] = 6'h00;
                run_one(w, 1'($urandom), fm && j[1]);
            end
        end
        print_verdict();
    end
endmodule
`default_nettype wire
